// file: bench/adc_front_model.sv
/*
 * Analog front end model: presents the gained, signed sample.
 * Assumes the bench sets the level before each start.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_front_model (
  // Clock, converter state and input level
  input wire logic mclk_i,
  input wire logic conv_busy_i,
  input wire logic [10:0] level_i,
  // Sample to the converter
  output logic [10:0] sar_sample_o
);
  logic [10:0] junk = 11'h555;
  // Outside a conversion nothing holds the line, so it toggles
  always_ff @(posedge mclk_i) begin
    junk <= ~junk;
  end
  assign sar_sample_o = conv_busy_i ? level_i : junk;
endmodule : adc_front_model
`default_nettype wire

// file: bench/adc_result_select_properties.sv
/*
 * Checker of bus timing and shadow freezing at the block's ports.
 * Assumes default conversion lengths.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_result_select_properties (
  // Clock, reset and bus
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Converter side
  input wire logic conv_start_o,
  input wire logic conv_busy_o,
  input wire logic [1:0] ref_select_o,
  input wire logic [5:0] channel_o,
  input wire logic bipolar_o
);
  localparam int BUSY_MAX = 27;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  a_ack_follows_req: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  a_ack_one_cycle: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_has_cause: assert property (
    wb_ack_o |-> $past(wb_stb_i)) else $error("stray ack");
  a_read_upper_zero: assert property (
    wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_start_sets_busy: assert property (
    conv_start_o |-> conv_busy_o) else $error("start without busy");
  a_busy_bounded: assert property (
    $rose(conv_busy_o) |-> conv_busy_o[*8] ##[1:BUSY_MAX] !conv_busy_o)
    else $error("busy length wrong");
  a_ref_frozen: assert property (
    conv_busy_o && $past(conv_busy_o) |-> $stable(ref_select_o))
    else $error("reference moved");
  a_chan_frozen: assert property (
    conv_busy_o && $past(conv_busy_o) |-> $stable(channel_o))
    else $error("channel moved");
  a_bip_frozen: assert property (
    conv_busy_o && $past(conv_busy_o) |-> $stable(bipolar_o))
    else $error("mode moved");
endmodule : adc_result_select_properties
bind adc_result_select adc_result_select_properties
  adc_result_select_properties_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .conv_start_o(conv_start_o),
  .conv_busy_o(conv_busy_o), .ref_select_o(ref_select_o),
  .channel_o(channel_o), .bipolar_o(bipolar_o));
`default_nettype wire

// file: bench/tb_adc_result_select.sv
/*
 * Testbench: register access, result formats, decode and deferral.
 * Assumes default conversion lengths and a 25 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_adc_result_select;
  import adc_sel_pkg::*;
  localparam logic [7:0] A_CB = {IDX_CONTROL_B, 2'h0};
  localparam logic [7:0] A_LO = {IDX_RESULT_LOW, 2'h0};
  localparam logic [7:0] A_HI = {IDX_RESULT_HIGH, 2'h0};
  localparam logic [7:0] A_CC = {IDX_CONV_CONTROL, 2'h0};
  localparam logic [7:0] A_IS = {IDX_INPUT_SELECT, 2'h0};
  localparam logic [7:0] R_ADR [5] = '{A_IS, A_CB, A_LO, A_HI, 8'h20};
  // Format table: select, sample, mode, result, {dif,g20,swp,tmp,bip}
  localparam logic [7:0] T_SEL [7] = '{8'h83, 8'h83, 8'hA2, 8'h09, 8'h08,
    8'h28, 8'h29};
  localparam logic [10:0] T_SMP [7] = '{11'h1FF, 11'h7FF, 11'h3FF, 11'h7FB,
    11'h123, 11'h700, 11'h3FF};
  localparam logic T_BIP [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  localparam logic [9:0] T_EXP [7] = '{10'h1FF, 10'h000, 10'h3FF, 10'h000,
    10'h123, 10'h380, 10'h1FF};
  localparam logic [4:0] T_FLG [7] = '{5'h00, 5'h00, 5'h02, 5'h18, 5'h10,
    5'h15, 5'h1D};
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack, start, busy, dif, g20, swp, tmp, bip;
  logic [10:0] level = 11'h000;
  logic [10:0] sample;
  logic [1:0] refs;
  logic [5:0] chan;
  logic [9:0] res;
  int n_mismatch = 0;
  int total_checks = 0;
  // Free running bus and converter clock
  always #20 mclk_i = ~mclk_i;
  adc_result_select adc_result_select_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .sar_sample_i(sample), .conv_start_o(start),
    .conv_busy_o(busy), .ref_select_o(refs), .channel_o(chan),
    .diff_mode_o(dif), .gain_20x_o(g20), .swap_o(swp),
    .temp_sensor_en_o(tmp), .bipolar_o(bip));
  adc_front_model adc_front_model_inst (.mclk_i(mclk_i), .conv_busy_i(busy),
    .level_i(level), .sar_sample_o(sample));
  // Classic single cycle; held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a,
    input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    @(posedge mclk_i);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge mclk_i);
      n++;
    end
    if (n == 50) n_mismatch++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask : wb_cycle
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Poll busy, then see the done flag and clear it
  task automatic wait_done;
    int n;
    n = 0;
    rd = 32'h00000002;
    while (rd[BUSY_BIT] !== 1'b0 && n < 30) begin
      wb_cycle(1'b0, A_CC, 8'h00);
      n++;
    end
    check({9'h000, rd[DONE_BIT]}, 10'h001);
    wb_cycle(1'b1, A_CC, 8'h10);
  endtask : wait_done
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_mismatch++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 5; i++) begin
      wb_cycle(1'b0, R_ADR[i], 8'h00);
      check(rd[9:0], 10'h000);
    end
    $display("reset test done");
    // code 11 is never written by this bench
    for (int i = 0; i < 3; i++) begin
      wb_cycle(1'b1, A_IS, {i[1:0], 6'h01});
      wb_cycle(1'b0, A_IS, 8'h00);
      check(rd[9:0], {2'h0, i[1:0], 6'h01});
      check({8'h00, refs}, {8'h00, i[1:0]});
    end
    $display("reference test done");
    for (int k = 0; k < 7; k++) begin
      wb_cycle(1'b1, A_CB, {7'h00, T_BIP[k]});
      wb_cycle(1'b1, A_IS, T_SEL[k]);
      // temperature entry uses the internal reference, single start
      repeat (25) @(posedge mclk_i);
      level <= T_SMP[k];
      wb_cycle(1'b1, A_CC, 8'h01);
      wait_done();
      wb_cycle(1'b0, A_LO, 8'h00);
      res[7:0] = rd[7:0];
      wb_cycle(1'b0, A_HI, 8'h00);
      res[9:8] = rd[1:0];
      check(res, T_EXP[k]);
      check({9'h000, rd[1]}, {9'h000, T_EXP[k][9]});
      check({5'h00, dif, g20, swp, tmp, bip}, {5'h00, T_FLG[k]});
      $display("format test %0d done", k);
    end
    // Selection rewritten during a running conversion
    wb_cycle(1'b1, A_CB, 8'h00);
    wb_cycle(1'b1, A_IS, 8'h83);
    wb_cycle(1'b1, A_CC, 8'h01);
    wb_cycle(1'b1, A_IS, 8'h45);
    check({4'h0, chan}, 10'h003);
    check({8'h00, refs}, 10'h002);
    wait_done();
    wb_cycle(1'b0, A_CC, 8'h00);
    check({9'h000, rd[DONE_BIT]}, 10'h000);
    check({4'h0, chan}, 10'h005);
    check({8'h00, refs}, 10'h001);
    $display("deferral test done");
    complete_run();
  end
endmodule : tb_adc_result_select
`default_nettype wire

// file: core/adc_chan_decode.sv
/*
 * Combinational decoder of the six-bit channel and gain field.
 * Assumes the caller registers its outputs.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_chan_decode
  import adc_sel_pkg::*;
(
  // Channel field
  input wire logic [5:0] chan_i,
  // Decoded selection
  output logic diff_o,
  output logic calib_o,
  output logic gain_20x_o,
  output logic swap_o,
  output logic temp_en_o
);
  wire logic normal_pair;
  wire logic reversed_pair;

  assign normal_pair = ~chan_i[5] & (chan_i[4:3] != 2'h0);
  assign reversed_pair = chan_i[5] & (chan_i[4:3] != 2'h0);
  assign calib_o = (chan_i >= CHAN_CALIB_FIRST) &&
                   (chan_i <= CHAN_CALIB_LAST);
  // single inputs, ground and reference are not differential
  assign diff_o = normal_pair | reversed_pair | calib_o;
  assign gain_20x_o = diff_o & chan_i[0];
  assign swap_o = reversed_pair;
  assign temp_en_o = (chan_i == CHAN_TEMPERATURE);
endmodule : adc_chan_decode
`default_nettype wire

// file: core/adc_result_format.sv
/*
 * Shapes the converter's signed sample into the 10-bit result format.
 * Assumes the sample is the gained difference times 1024 over the
 * reference, already saturated to 11 bits signed.
 */
`timescale 1ns/1ns
`default_nettype none
module adc_result_format
  import adc_sel_pkg::*;
(
  // Sample and mode
  input wire logic [10:0] sample_i,
  input wire logic diff_i,
  input wire logic bipolar_i,
  // Formatted result
  output logic [9:0] result_o
);
  wire logic negative;
  wire logic [9:0] one_sided;
  wire logic [9:0] two_sided;

  assign negative = sample_i[10];
  // one-sided code, negative clamps to zero
  // An 11-bit signed sample tops out at 0x3FF, so no upper clamp is needed
  assign one_sided = negative ? RESULT_ZERO : sample_i[9:0];
  // halving the 1024 scale gives the 512 scale, sign kept
  assign two_sided = sample_i[10:1];
  // bipolar only applies to differential selections
  assign result_o = (diff_i & bipolar_i) ? two_sided : one_sided;
endmodule : adc_result_format
`default_nettype wire

// file: core/adc_result_select.sv
/*
 * Converter result and input select block: Wishbone classic slave holding
 * input select, control B, conversion control and the two result registers,
 * the shadowed reference and channel that drive the analog front end, and
 * the conversion sequencer.
 * Assumes the analog side presents sar_sample_i stable during the last
 * clock of a conversion and that one clock is both bus and converter clock.
 */
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ns
`default_nettype none
module adc_result_select
  import adc_sel_pkg::*;
#(
  parameter int CONV_LEN = CONV_CYCLES,
  parameter int FIRST_CONV_LEN = FIRST_CONV_CYCLES
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog converter side
  input wire logic [10:0] sar_sample_i,
  output logic conv_start_o,
  output logic conv_busy_o,
  output logic [1:0] ref_select_o,
  output logic [5:0] channel_o,
  output logic diff_mode_o,
  output logic gain_20x_o,
  output logic swap_o,
  output logic temp_sensor_en_o,
  output logic bipolar_o
);
  // Elaboration check on timing parameters
  if (CONV_LEN < 2 || CONV_LEN > 255 ||
      FIRST_CONV_LEN < CONV_LEN || FIRST_CONV_LEN > 255) begin : g_chk
    $error("conversion lengths out of range");
  end

  // Software visible registers
  logic [7:0] input_select;
  logic [7:0] control_b;
  logic [9:0] result;
  logic done_flag;
  // Shadow of reference and channel used by the converter
  logic [1:0] ref_shadow;
  logic [5:0] chan_shadow;
  // Sequencer
  conv_state_t state;
  conv_state_t next_state;
  logic [7:0] cycle_cnt;
  logic initialised;

  // Bus decode
  wire logic bus_req;
  wire logic wr_stb;
  wire logic lane0;
  wire logic [5:0] reg_idx;
  wire logic addr_ok;
  wire logic wr_select;
  wire logic wr_ctrl_b;
  wire logic wr_conv;
  wire logic start_req;
  wire logic done_clear;
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stb = bus_req & wb_we_i & wb_sel_i[0];
  assign lane0 = wb_sel_i[0];
  assign reg_idx = wb_adr_i[7:2];
  assign addr_ok = (wb_adr_i[1:0] == 2'h0);
  assign wr_select = wr_stb & addr_ok & (reg_idx == IDX_INPUT_SELECT);
  assign wr_ctrl_b = wr_stb & addr_ok & (reg_idx == IDX_CONTROL_B);
  assign wr_conv = wr_stb & addr_ok & (reg_idx == IDX_CONV_CONTROL);
  assign start_req = wr_conv & wb_dat_i[START_BIT];
  assign done_clear = wr_conv & wb_dat_i[DONE_BIT];

  // Sequencer decode
  wire logic idle;
  wire logic last_cycle;
  wire logic [7:0] conv_len_now;
  assign idle = (state == ST_IDLE);
  assign conv_len_now = initialised ? 8'(CONV_LEN) : 8'(FIRST_CONV_LEN);
  assign last_cycle = (state == ST_CONVERT) &&
                      (cycle_cnt == conv_len_now - 8'h01);

  // Shadow follows the register while idle, frozen during a conversion
  wire logic [1:0] next_ref_shadow;
  wire logic [5:0] next_chan_shadow;
  wire logic [7:0] next_input_select;
  assign next_input_select = wr_select ? wb_dat_i[7:0] : input_select;
  assign next_ref_shadow = idle ? next_input_select[REF_LSB +: 2] :
                           ref_shadow;
  assign next_chan_shadow = idle ? next_input_select[CHAN_LSB +: 6] :
                            chan_shadow;

  // Channel decode of the shadowed selection
  logic dec_diff;
  logic dec_calib;
  logic dec_gain;
  logic dec_swap;
  logic dec_temp;
  adc_chan_decode u_decode (
    .chan_i(next_chan_shadow),
    .diff_o(dec_diff),
    .calib_o(dec_calib),
    .gain_20x_o(dec_gain),
    .swap_o(dec_swap),
    .temp_en_o(dec_temp)
  );

  // Result shaping from the converter sample
  logic [9:0] formatted;
  adc_result_format u_format (
    .sample_i(sar_sample_i),
    .diff_i(diff_mode_o),
    .bipolar_i(bipolar_o),
    .result_o(formatted)
  );

  // Sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (last_cycle) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer state and cycle count
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      cycle_cnt <= 8'h00;
      initialised <= 1'b0;
    end else begin
      state <= next_state;
      cycle_cnt <= idle ? 8'h00 : cycle_cnt + 8'h01;
      if (last_cycle) begin
        initialised <= 1'b1;
      end
    end
  end

  // Software written registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      input_select <= INPUT_SELECT_RESET;
      control_b <= CONTROL_B_RESET;
    end else begin
      input_select <= next_input_select;
      if (wr_ctrl_b) begin
        control_b <= wb_dat_i[7:0];
      end
    end
  end

  // Result capture and done flag; completion wins over a clear
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      result <= RESULT_ZERO;
      done_flag <= 1'b0;
    end else if (last_cycle) begin
      result <= formatted;
      done_flag <= 1'b1;
    end else if (done_clear) begin
      done_flag <= 1'b0;
    end
  end

  // Front end controls, all registered
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ref_shadow <= REF_SUPPLY;
      chan_shadow <= 6'h00;
      ref_select_o <= REF_SUPPLY;
      channel_o <= 6'h00;
      diff_mode_o <= 1'b0;
      gain_20x_o <= 1'b0;
      swap_o <= 1'b0;
      temp_sensor_en_o <= 1'b0;
      bipolar_o <= 1'b0;
      conv_start_o <= 1'b0;
      conv_busy_o <= 1'b0;
    end else begin
      ref_shadow <= next_ref_shadow;
      chan_shadow <= next_chan_shadow;
      // reference code drives the reference switch
      ref_select_o <= next_ref_shadow;
      channel_o <= next_chan_shadow;
      // one field yields pair and gain
      diff_mode_o <= dec_diff;
      gain_20x_o <= dec_gain;
      swap_o <= dec_swap;
      temp_sensor_en_o <= dec_temp;
      bipolar_o <= idle ? control_b[BIPOLAR_BIT] : bipolar_o;
      conv_start_o <= idle & start_req;
      conv_busy_o <= (next_state == ST_CONVERT);
    end
  end

  // Read mux; calibration selections read like other differential pairs
  wire logic [7:0] rd_byte;
  wire logic unused_ok;
  assign unused_ok = dec_calib;
  // result MSB sits in bit 1 of the high register
  assign rd_byte =
    ~addr_ok ? 8'h00 :
    (reg_idx == IDX_INPUT_SELECT) ? input_select :
    (reg_idx == IDX_CONTROL_B) ? control_b :
    (reg_idx == IDX_RESULT_LOW) ? result[7:0] :
    (reg_idx == IDX_RESULT_HIGH) ? {6'h00, result[9:8]} :
    (reg_idx == IDX_CONV_CONTROL) ?
      {3'h0, done_flag, 2'h0, ~idle, 1'b0} : 8'h00;

  // Bus answer one cycle after the request
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i) begin
        wb_dat_o <= {24'h00_0000, lane0 ? rd_byte : 8'h00};
      end
    end
  end
endmodule : adc_result_select
`default_nettype wire

// file: core/adc_sel_pkg.sv
/*
 * Constants for the converter result and input select block: register
 * indices, field positions, reset values and conversion timing.
 * Assumes a 25 MHz converter clock equal to the bus clock.
 */
// Notes on behaviour
// - Finished value lands in both result registers before done flag is seen.
// - Single-ended code is Vin*1024/Vref, 0x000 ground to 0x3FF.
// - Unipolar differential is unsigned 0x000..0x3FF, clamped to zero if negative.
// - Bipolar differential is difference*512/Vref, two's complement 0x200..0x1FF.
// - In bipolar mode result MSB in high register marks a negative result.
// - Differential conversions apply gain 1x or 20x chosen by channel field.
// - Unipolar by default; bipolar select bit in control B picks bipolar.
// - Channel code 100010 routes and enables the temperature sensor single-ended.
// - Reference field bits 7:6: 00 supply, 01 external pin, 10 internal 1.1V.
// - Reference written mid-conversion takes effect only after completion.
// - Channel written mid-conversion takes effect only after completion.
// - Codes 000000-000111 single inputs, 100000 ground, 100001 internal reference.
// - Decode differential, offset calibration and polarity-reversed pair ranges.
// - One channel field write sets both input pair and gain.
// - Lowest channel bit picks gain: clear 1x, set 20x.
// - Top channel bit swaps positive and negative inputs of normal pairs.
package adc_sel_pkg;
  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL_B = 6'h03;
  localparam logic [5:0] IDX_RESULT_LOW = 6'h04;
  localparam logic [5:0] IDX_RESULT_HIGH = 6'h05;
  localparam logic [5:0] IDX_CONV_CONTROL = 6'h06;
  localparam logic [5:0] IDX_INPUT_SELECT = 6'h07;
  // Input select fields
  localparam int REF_LSB = 6;
  localparam int CHAN_LSB = 0;
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  // Control B and conversion control bits
  localparam int BIPOLAR_BIT = 0;
  localparam int START_BIT = 0;
  localparam int BUSY_BIT = 1;
  localparam int DONE_BIT = 4;
  localparam logic [7:0] CONTROL_B_RESET = 8'h00;
  // Reference codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT_PIN = 2'h1;
  localparam logic [1:0] REF_INTERNAL = 2'h2;
  // Special channel codes
  localparam logic [5:0] CHAN_GROUND = 6'h20;
  localparam logic [5:0] CHAN_INT_REF = 6'h21;
  localparam logic [5:0] CHAN_TEMPERATURE = 6'h22;
  localparam logic [5:0] CHAN_CALIB_FIRST = 6'h23;
  localparam logic [5:0] CHAN_CALIB_LAST = 6'h27;
  // Result limits
  localparam logic [9:0] RESULT_MAX = 10'h3FF;
  localparam logic [9:0] RESULT_ZERO = 10'h000;
  // Conversion length in converter clocks
  localparam int CONV_CYCLES = 13;
  localparam int FIRST_CONV_CYCLES = 25;
  // Conversion states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
endpackage : adc_sel_pkg
